// [src/pfs_pkg.sv]
// Constants, function codes and carrier types for the pad function select block.
package pfs_pkg;

	localparam int PFS_NPIN = 6;
	localparam int PFS_FW = 4;

	// Pin indices inside the block.
	localparam int PFS_P0_0 = 0;
	localparam int PFS_P0_2 = 1;
	localparam int PFS_P0_9 = 2;
	localparam int PFS_P0_11 = 3;
	localparam int PFS_P1_8 = 4;
	localparam int PFS_P1_9 = 5;

	// Function codes held in each pin's select field.
	localparam logic [3:0] PFS_FN_GPIO = 4'h0;
	localparam logic [3:0] PFS_FN_RESET = 4'h1;
	localparam logic [3:0] PFS_FN_SWDAT = 4'h2;
	localparam logic [3:0] PFS_FN_SWCLK = 4'h3;
	localparam logic [3:0] PFS_FN_UART = 4'h4;
	localparam logic [3:0] PFS_FN_SPI_DATA = 4'h5;
	localparam logic [3:0] PFS_FN_SPI_CLK = 4'h6;
	localparam logic [3:0] PFS_FN_I2C_SDA = 4'h7;
	localparam logic [3:0] PFS_FN_TIMER1_CHANNEL1 = 4'h8;
	localparam logic [3:0] PFS_FN_BREAK0 = 4'h9;
	localparam logic [3:0] PFS_FN_CH0_LOW = 4'hA;
	localparam logic [3:0] PFS_FN_CH3_LOW = 4'hB;
	localparam logic [3:0] PFS_FN_ANALOG = 4'hC;
	localparam logic [3:0] PFS_FN_CLKOUT = 4'hD;

	// One bit per function code that the pin can carry.
	localparam logic [15:0] PFS_LEGAL [PFS_NPIN] = '{16'h1211, 16'h0023, 16'h20B1, 16'h0541, 16'h0009, 16'h1995};

	// Pins fitted with a pull-up resistor, and their interrupt and wake-up numbers.
	localparam logic [5:0] PFS_PU_MASK = 6'h36;
	localparam logic [5:0] PFS_IRQ_MASK = 6'h27;
	localparam logic [3:0] PFS_IRQ_NUM [PFS_NPIN] = '{4'h0, 4'h1, 4'h7, 4'h0, 4'h0, 4'hF};
	localparam logic [2:0] PFS_WAKE_NUM [PFS_NPIN] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h0, 3'h7};

	// Register byte offsets.
	localparam logic [7:0] PFS_OFS_FUNC = 8'h00;
	localparam logic [7:0] PFS_OFS_IE = 8'h04;
	localparam logic [7:0] PFS_OFS_OE = 8'h08;
	localparam logic [7:0] PFS_OFS_PULL = 8'h0C;
	localparam logic [7:0] PFS_OFS_DOUT = 8'h10;
	localparam logic [7:0] PFS_OFS_DIN = 8'h14;
	localparam logic [7:0] PFS_OFS_PULLST = 8'h18;

	// Values after reset.
	localparam logic [23:0] PFS_RST_FUNC = 24'h230010;
	localparam logic [5:0] PFS_RST_IE = 6'h32;
	localparam logic [5:0] PFS_RST_OE = 6'h00;
	localparam logic [5:0] PFS_RST_PULL = 6'h00;
	localparam logic [5:0] PFS_RST_DOUT = 6'h00;
	// Pull-ups that the reset, debug clock and debug data functions force on after reset.
	localparam logic [5:0] PFS_RST_PU = 6'h32;

	typedef struct packed {
		logic uart_tx;
		logic spi_dout;
		logic spi_sclk;
		logic i2c_sda_out;
		logic timer1_channel1_out;
		logic motor_ch0_low_side;
		logic motor_ch3_low_side;
		logic clk_debug;
		logic swd_dout;
		logic swd_doe;
	} pfs_periph_out_type;

	typedef struct packed {
		logic uart_rx;
		logic serial_in_line;
		logic i2c_sda_in;
		logic timer1_channel1_in;
		logic motor_break_input0;
		logic swd_din;
		logic swd_clk;
		logic chip_reset_pin_n;
		logic converter_channel10;
		logic converter_channel9;
	} pfs_periph_in_type;

endpackage

// [src/pfs_pad_function_select.sv]
// Pad function multiplexer with pull-up control and an APB register file.
//
// Functional notes
// - UART pin: input enable receives, output transmits
// - SPI data pin: input enable in, output out
// - Both enables: pad output loops into input
// - Port 0 pin 2 is reset after reset
// - Reset pin pull-up forced while reset function
// - Debug pin pull-ups forced while debug function
// - Other pull-up pins: independent software bit
// - P0.0: break, UART, ADC10, irq0, wake0
// - P1.9: debug, ch3 low, UART, I2C, timer, ADC9
// - P0.11: ch0 low, SPI clock, timer, GPIO
`timescale 1ns/1ps
module pfs_pad_function_select
	import pfs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pfs_pkg::pfs_periph_out_type periph_out,
	output pfs_pkg::pfs_periph_in_type periph_in,
	output logic [15:0] external_irq_line,
	output logic [7:0] wake_source,
	input wire logic [5:0] pad_data_in,
	output logic [5:0] pad_data_out,
	output logic [5:0] pad_output_enable,
	output logic [5:0] pad_input_enable,
	output logic [5:0] weak_high_resistor
);
	import pfs_pkg::*;

	logic [23:0] func_q;
	logic [5:0] ie_q;
	logic [5:0] oe_q;
	logic [5:0] pull_q;
	logic [5:0] dout_q;
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] pad_dout_d;
	logic [5:0] pad_oe_d;
	logic [5:0] pad_ie_d;
	logic [5:0] pull_d;
	logic [5:0] pin_in;
	logic [3:0] fn [PFS_NPIN];
	logic [23:0] func_d;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic first_q;

	always_comb
	begin
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			fn[i] = func_q[i*PFS_FW +: PFS_FW];
		end
	end

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		case (paddr)
			PFS_OFS_FUNC, PFS_OFS_IE, PFS_OFS_OE, PFS_OFS_PULL, PFS_OFS_DOUT, PFS_OFS_DIN, PFS_OFS_PULLST:
				hit = 1'b1;
			default:
				hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !hit;

	// A code the pin cannot carry leaves that pin's field unchanged.
	always_comb
	begin
		func_d = func_q;
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			if (PFS_LEGAL[i][pwdata[i*PFS_FW +: PFS_FW]])
			begin
				func_d[i*PFS_FW +: PFS_FW] = pwdata[i*PFS_FW +: PFS_FW];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			func_q <= PFS_RST_FUNC;
		end
		else if (wr_en && paddr == PFS_OFS_FUNC)
		begin
			func_q <= func_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ie_q <= PFS_RST_IE;
			oe_q <= PFS_RST_OE;
			pull_q <= PFS_RST_PULL;
			dout_q <= PFS_RST_DOUT;
		end
		else if (wr_en)
		begin
			case (paddr)
				PFS_OFS_IE: ie_q <= pwdata[5:0];
				PFS_OFS_OE: oe_q <= pwdata[5:0];
				PFS_OFS_PULL: pull_q <= pwdata[5:0] & PFS_PU_MASK;
				PFS_OFS_DOUT: dout_q <= pwdata[5:0];
				default: ;
			endcase
		end
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_en)
		begin
			case (paddr)
				PFS_OFS_FUNC: prdata = {8'h00, func_q};
				PFS_OFS_IE: prdata = {26'h0, ie_q};
				PFS_OFS_OE: prdata = {26'h0, oe_q};
				PFS_OFS_PULL: prdata = {26'h0, pull_q};
				PFS_OFS_DOUT: prdata = {26'h0, dout_q};
				PFS_OFS_DIN: prdata = {26'h0, pin_in};
				PFS_OFS_PULLST: prdata = {26'h0, weak_high_resistor};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Stages start at the pull-up level, so the reset pin shows no false low after reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q <= PFS_RST_PU;
			sync2_q <= PFS_RST_PU;
		end
		else
		begin
			sync1_q <= pad_data_in;
			sync2_q <= sync1_q;
		end
	end

	// Drive, direction and pull for each pin from its selected function.
	always_comb
	begin
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			pad_dout_d[i] = dout_q[i];
			pad_oe_d[i] = oe_q[i];
			pad_ie_d[i] = ie_q[i];
			pull_d[i] = pull_q[i];
			case (fn[i])
				PFS_FN_UART: pad_dout_d[i] = periph_out.uart_tx;
				PFS_FN_SPI_DATA: pad_dout_d[i] = periph_out.spi_dout;
				PFS_FN_SPI_CLK: pad_dout_d[i] = periph_out.spi_sclk;
				PFS_FN_TIMER1_CHANNEL1: pad_dout_d[i] = periph_out.timer1_channel1_out;
				PFS_FN_CH0_LOW: pad_dout_d[i] = periph_out.motor_ch0_low_side;
				PFS_FN_CH3_LOW: pad_dout_d[i] = periph_out.motor_ch3_low_side;
				PFS_FN_CLKOUT: pad_dout_d[i] = periph_out.clk_debug;
				PFS_FN_I2C_SDA:
				begin
					// Open drain: only a low is driven.
					pad_dout_d[i] = 1'b0;
					pad_oe_d[i] = oe_q[i] && !periph_out.i2c_sda_out;
				end
				PFS_FN_SWDAT:
				begin
					pad_dout_d[i] = periph_out.swd_dout;
					pad_oe_d[i] = periph_out.swd_doe;
					pad_ie_d[i] = 1'b1;
					pull_d[i] = 1'b1;
				end
				PFS_FN_SWCLK, PFS_FN_RESET:
				begin
					pad_oe_d[i] = 1'b0;
					pad_ie_d[i] = 1'b1;
					pull_d[i] = 1'b1;
				end
				PFS_FN_BREAK0: pad_oe_d[i] = 1'b0;
				PFS_FN_ANALOG:
				begin
					// The analog switch must not see the digital buffers.
					pad_oe_d[i] = 1'b0;
					pad_ie_d[i] = 1'b0;
				end
				default: ;
			endcase
			pull_d[i] = pull_d[i] && PFS_PU_MASK[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_data_out <= PFS_RST_DOUT;
			pad_output_enable <= PFS_RST_OE;
			pad_input_enable <= PFS_RST_IE;
			weak_high_resistor <= PFS_RST_PU;
		end
		else
		begin
			pad_data_out <= pad_dout_d;
			pad_output_enable <= pad_oe_d;
			pad_input_enable <= pad_ie_d;
			weak_high_resistor <= pull_d;
		end
	end

	// With both enables set the receiver sees the pad's own driven value.
	always_comb
	begin
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			pin_in[i] = pad_input_enable[i] && (pad_output_enable[i] ? pad_data_out[i] : sync2_q[i]);
		end
	end

	// Inputs to the peripherals; an unselected input rests at its idle level.
	always_comb
	begin
		periph_in = '0;
		periph_in.uart_rx = 1'b1;
		periph_in.swd_din = 1'b1;
		periph_in.chip_reset_pin_n = 1'b1;
		periph_in.converter_channel10 = fn[PFS_P0_0] == PFS_FN_ANALOG;
		periph_in.converter_channel9 = fn[PFS_P1_9] == PFS_FN_ANALOG;
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			if (ie_q[i] || fn[i] == PFS_FN_RESET || fn[i] == PFS_FN_SWDAT || fn[i] == PFS_FN_SWCLK)
			begin
				case (fn[i])
					PFS_FN_UART: periph_in.uart_rx = pin_in[i];
					PFS_FN_SPI_DATA: periph_in.serial_in_line = pin_in[i];
					PFS_FN_I2C_SDA: periph_in.i2c_sda_in = pin_in[i];
					PFS_FN_TIMER1_CHANNEL1: periph_in.timer1_channel1_in = pin_in[i];
					PFS_FN_BREAK0: periph_in.motor_break_input0 = pin_in[i];
					PFS_FN_SWDAT: periph_in.swd_din = pin_in[i];
					PFS_FN_SWCLK: periph_in.swd_clk = pin_in[i];
					PFS_FN_RESET: periph_in.chip_reset_pin_n = pin_in[i];
					default: ;
				endcase
			end
		end
	end

	always_comb
	begin
		external_irq_line = 16'h0000;
		wake_source = 8'h00;
		for (int i = 0; i < PFS_NPIN; i++)
		begin
			if (PFS_IRQ_MASK[i] && fn[i] == PFS_FN_GPIO)
			begin
				external_irq_line[PFS_IRQ_NUM[i]] = pin_in[i];
				wake_source[PFS_WAKE_NUM[i]] = pin_in[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_q <= 1'b1;
		end
		else
		begin
			first_q <= 1'b0;
		end
	end

	AST_UART_TX: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_0] == PFS_FN_UART && oe_q[PFS_P0_0])
		|=> (pad_data_out[PFS_P0_0] == $past(periph_out.uart_tx) && pad_output_enable[PFS_P0_0]))
		else $error("UART transmit not on pad");

	AST_SPI_IN: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_2] == PFS_FN_SPI_DATA && pad_input_enable[PFS_P0_2] && !pad_output_enable[PFS_P0_2]
		&& fn[PFS_P0_9] != PFS_FN_SPI_DATA && ie_q[PFS_P0_2])
		|-> periph_in.serial_in_line == sync2_q[PFS_P0_2])
		else $error("Serial data in not from pad");

	AST_LOOPBACK: assert property (@(posedge pclk) disable iff (!presetn)
		(pad_input_enable[PFS_P0_9] && pad_output_enable[PFS_P0_9])
		|-> pin_in[PFS_P0_9] == pad_data_out[PFS_P0_9])
		else $error("Loopback missing");

	AST_RESET_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
		first_q |-> (fn[PFS_P0_2] == PFS_FN_RESET && periph_in.chip_reset_pin_n == pin_in[PFS_P0_2]))
		else $error("Reset pin not reset function after reset");

	AST_RESET_PULL: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_2] == PFS_FN_RESET) [*2] |-> weak_high_resistor[PFS_P0_2])
		else $error("Reset pin pull-up off");

	AST_SWD_PULL: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P1_9] == PFS_FN_SWDAT && fn[PFS_P1_8] == PFS_FN_SWCLK)
		|=> (weak_high_resistor[PFS_P1_9] && weak_high_resistor[PFS_P1_8]))
		else $error("Debug pull-up off");

	AST_SW_PULL: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_9] == PFS_FN_GPIO) |=> weak_high_resistor[PFS_P0_9] == $past(pull_q[PFS_P0_9]))
		else $error("Pull-up does not follow control bit");

	AST_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_0] == PFS_FN_BREAK0 && ie_q[PFS_P0_0] && pad_input_enable[PFS_P0_0])
		|-> periph_in.motor_break_input0 == pin_in[PFS_P0_0])
		else $error("Break input not routed");

	AST_CH3_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P1_9] == PFS_FN_CH3_LOW) |=> pad_data_out[PFS_P1_9] == $past(periph_out.motor_ch3_low_side))
		else $error("Channel 3 low side not routed");

	AST_SPI_CLK: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_11] == PFS_FN_SPI_CLK) |=> pad_data_out[PFS_P0_11] == $past(periph_out.spi_sclk))
		else $error("Serial clock not routed");

	AST_OE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		(!oe_q[PFS_P0_11]) |=> !pad_output_enable[PFS_P0_11])
		else $error("Pad driven without output enable");

	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		(fn[PFS_P0_0] == PFS_FN_GPIO && !pad_output_enable[PFS_P0_0] && pad_input_enable[PFS_P0_0])
		|-> (external_irq_line[0] == sync2_q[PFS_P0_0] && wake_source[0] == sync2_q[PFS_P0_0]))
		else $error("Interrupt line not following pad");

endmodule

// [tb/pfs_pad_partner.sv]
// Model of the board circuitry attached to the block's package pins.
`timescale 1ns/1ps
module pfs_pad_partner
(
	input wire logic pclk,
	input wire logic [5:0] pad_data_out,
	input wire logic [5:0] pad_output_enable,
	input wire logic [5:0] weak_high_resistor,
	input wire logic [5:0] ext_drive_en,
	input wire logic [5:0] ext_value,
	output logic [5:0] pad_data_in
);
	logic [5:0] float_q = 6'h00;
	// An undriven pin without pull-up has no level, so it is made to flip every cycle.
	always_ff @(posedge pclk)
	begin
		float_q <= ~pad_data_in;
	end
	// A strong board driver overrides the pad's own output, which exposes the internal loopback.
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			if (ext_drive_en[i])
				pad_data_in[i] = ext_value[i];
			else if (pad_output_enable[i])
				pad_data_in[i] = pad_data_out[i];
			else if (weak_high_resistor[i])
				pad_data_in[i] = 1'b1;
			else
				pad_data_in[i] = float_q[i];
		end
	end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the pad function select block.
`timescale 1ns/1ps
module testbench;
	import pfs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pfs_periph_out_type periph_out = '0;
	pfs_periph_in_type periph_in;
	logic [15:0] external_irq_line;
	logic [7:0] wake_source;
	logic [5:0] pad_data_in;
	logic [5:0] pad_data_out;
	logic [5:0] pad_output_enable;
	logic [5:0] pad_input_enable;
	logic [5:0] weak_high_resistor;
	logic [5:0] ext_en = 6'h00;
	logic [5:0] ext_val = 6'h00;
	logic [31:0] rd;
	logic er;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;

	pfs_pad_function_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_out(periph_out), .periph_in(periph_in),
		.external_irq_line(external_irq_line), .wake_source(wake_source), .pad_data_in(pad_data_in),
		.pad_data_out(pad_data_out), .pad_output_enable(pad_output_enable),
		.pad_input_enable(pad_input_enable), .weak_high_resistor(weak_high_resistor));

	pfs_pad_partner board (.pclk(pclk), .pad_data_out(pad_data_out), .pad_output_enable(pad_output_enable),
		.weak_high_resistor(weak_high_resistor), .ext_drive_en(ext_en), .ext_value(ext_val),
		.pad_data_in(pad_data_in));

	initial
	begin
		forever #25 pclk = ~pclk;
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			wrap_up;
		end
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	// Register write, one edge to the pads and two synchroniser edges back.
	task settle;
		repeat (4) @(posedge pclk);
	endtask

	task t_reset;
		rdchk("func", PFS_OFS_FUNC, 32'h00230010);
		rdchk("pullst", PFS_OFS_PULLST, 32'h00000032);
		apb(1'b0, 8'h1C, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		ext_en <= 6'h02;
		ext_val <= 6'h00;
		settle;
		chk("rst_pin", 32'h0, 32'(periph_in.chip_reset_pin_n));
		ext_en <= 6'h00;
	endtask

	task t_uart;
		apb(1'b1, PFS_OFS_FUNC, 32'h00230014);
		apb(1'b1, PFS_OFS_IE, 32'h00000033);
		ext_en <= 6'h01;
		ext_val <= 6'h00;
		settle;
		chk("uart_rx", 32'h0, 32'(periph_in.uart_rx));
		ext_en <= 6'h00;
		apb(1'b1, PFS_OFS_IE, 32'h00000032);
		apb(1'b1, PFS_OFS_OE, 32'h00000001);
		periph_out.uart_tx <= 1'b0;
		settle;
		chk("tx_low", 32'h2, 32'({pad_output_enable[0], pad_data_out[0]}));
		periph_out.uart_tx <= 1'b1;
		settle;
		chk("tx_high", 32'h1, 32'(pad_data_out[0]));
	endtask

	task t_loop;
		apb(1'b1, PFS_OFS_FUNC, 32'h00230510);
		apb(1'b1, PFS_OFS_OE, 32'h00000000);
		apb(1'b1, PFS_OFS_IE, 32'h00000036);
		ext_en <= 6'h04;
		ext_val <= 6'h04;
		settle;
		chk("spi_in", 32'h1, 32'(periph_in.serial_in_line));
		apb(1'b1, PFS_OFS_OE, 32'h00000004);
		ext_val <= 6'h00;
		periph_out.spi_dout <= 1'b1;
		settle;
		chk("loop_hi", 32'h1, 32'(periph_in.serial_in_line));
		periph_out.spi_dout <= 1'b0;
		settle;
		chk("loop_lo", 32'h0, 32'(periph_in.serial_in_line));
		ext_en <= 6'h00;
	endtask

	task t_pull;
		apb(1'b1, PFS_OFS_PULL, 32'h00000000);
		rdchk("forced", PFS_OFS_PULLST, 32'h00000032);
		apb(1'b1, PFS_OFS_PULL, 32'h00000004);
		rdchk("soft", PFS_OFS_PULLST, 32'h00000036);
		apb(1'b1, PFS_OFS_FUNC, 32'h00000500);
		rdchk("released", PFS_OFS_PULLST, 32'h00000004);
		settle;
		chk("pull_pins", 32'h4, 32'(weak_high_resistor));
	endtask

	task t_irq;
		apb(1'b1, PFS_OFS_OE, 32'h00000000);
		apb(1'b1, PFS_OFS_IE, 32'h00000001);
		ext_en <= 6'h01;
		ext_val <= 6'h01;
		settle;
		chk("irq_wake", 32'h3, 32'({external_irq_line[0], wake_source[0]}));
		apb(1'b1, PFS_OFS_IE, 32'h00000000);
		settle;
		chk("irq_off", 32'h0, 32'({external_irq_line[0], wake_source[0]}));
	endtask

	task t_route;
		apb(1'b1, PFS_OFS_FUNC, 32'h00B0A500);
		apb(1'b1, PFS_OFS_OE, 32'h00000028);
		periph_out.motor_ch0_low_side <= 1'b1;
		periph_out.motor_ch3_low_side <= 1'b1;
		settle;
		chk("low_hi", 32'h28, 32'(pad_data_out & 6'h28));
		periph_out.motor_ch0_low_side <= 1'b0;
		periph_out.motor_ch3_low_side <= 1'b0;
		settle;
		chk("low_lo", 32'h0, 32'(pad_data_out & 6'h28));
	endtask

	// Break, serial data in, serial clock and analog on their own pins; an illegal code is ignored.
	task t_alt;
		apb(1'b1, PFS_OFS_FUNC, 32'h00C06D59);
		rdchk("func_alt", PFS_OFS_FUNC, 32'h00C06D59);
		apb(1'b1, PFS_OFS_OE, 32'h00000028);
		apb(1'b1, PFS_OFS_IE, 32'h00000003);
		ext_en <= 6'h03;
		ext_val <= 6'h03;
		periph_out.spi_sclk <= 1'b1;
		settle;
		chk("break_in", 32'h1, 32'(periph_in.motor_break_input0));
		chk("spi_in_p02", 32'h1, 32'(periph_in.serial_in_line));
		chk("sclk_out", 32'h1, 32'(pad_data_out[3]));
		chk("adc9", 32'h1, 32'({periph_in.converter_channel10, periph_in.converter_channel9}));
		chk("alt_oe", 32'h08, 32'(pad_output_enable & 6'h28));
		apb(1'b1, PFS_OFS_FUNC, 32'h00C06D53);
		rdchk("func_illegal", PFS_OFS_FUNC, 32'h00C06D59);
		ext_en <= 6'h00;
	endtask

	initial
	begin
		repeat (7) @(posedge pclk);
		chk("pie_rst", 32'h32, 32'(pad_input_enable));
		chk("pu_rst", 32'h32, 32'(weak_high_resistor));
		@(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_uart;
		t_loop;
		t_pull;
		t_irq;
		t_route;
		t_alt;
		wrap_up;
	end
endmodule
